// ===== rtl/sfl_map.svh
// Constants of the serial flash lane interface: opcodes, counts, timing.
//
// Contract
// - Works with host clock mode 0 or 3.
// - Sample on rising, change outputs on falling.
// - Two-lane reads: opcodes 3B, 3C, BB, BC.
// - Two-lane: input/output lines become lanes 0, 1.
// - Two-lane moves two bits per clock.
// - Four-lane reads: opcodes 6B, 6C, EB, EC.
// - Four-lane: guard and pause pins become lanes 2, 3.
// - Four-lane commands need four-lane enable set.
// - Four-lane moves four bits per clock.
// - 256-byte pages, 4K sectors, 16 per block.
// - Dedicated reset input resets regardless of state.
// - Eight-pin: pause/reset pin doubles as lane 3.
// - Pin-function bit picks pause (0) or reset (1).
// - Pause/reset only while four-lane enable is 0.
// - Pause starts on pin fall with clock low.
// - Reset low at least 1 us restarts device.
`ifndef SFL_MAP_SVH
`define SFL_MAP_SVH

// ==========================================================
// Opcodes of the multi-lane read commands.
`define OP_DUAL_OUT3 8'h3b
`define OP_DUAL_OUT4 8'h3c
`define OP_DUAL_IO3 8'hbb
`define OP_DUAL_IO4 8'hbc
`define OP_QUAD_OUT3 8'h6b
`define OP_QUAD_OUT4 8'h6c
`define OP_QUAD_IO3 8'heb
`define OP_QUAD_IO4 8'hec

// ==========================================================
// Lane widths, phase lengths in shift clocks and chunk counts.
`define LW1 3'h1
`define LW2 3'h2
`define LW4 3'h4
`define OP_LAST 6'h07
`define ADDR3_CLK 6'h18
`define ADDR4_CLK 6'h20
`define DUMMY_OUT 6'h08
`define DUMMY_DIO 6'h04
`define DUMMY_QIO 6'h06
`define CHUNK2_LAST 3'h3
`define CHUNK4_LAST 3'h1
`define IDLE_BYTE 8'hff

// ==========================================================
// Array organisation: byte address bit fields.
`define SECTOR_LSB 12
`define SECTOR_MSB 24
`define BLOCK_LSB 16
`define BLOCK_MSB 24

// ==========================================================
// Timing: restart pulse minimum and clock period in ns.
`define RESTART_PULSE_MIN_NS 1000
`define CLK_PERIOD_NS 4
`define RESTART_CYC \
  8'((`RESTART_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Read data buffer shape.
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8

`endif

// ===== rtl/sfl_pkg.sv
// Types shared by the serial flash lane interface.
package sfl_pkg;
  // Phases of one selected frame.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfl_state_type;
endpackage

// ===== rtl/sfl_pin_sync.sv
// Two-stage pin synchroniser with edge detection per bit.
module sfl_pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  // ==========================================================
  // Synchroniser chain, one generate iteration per pin.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_r; // First stage: read by the second stage only.
      logic s2_r; // Settled level.
      logic s3_r; // Delayed level for edge detection.
      // Plain shift chain; reset to idle-high pin level.
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
        end else begin
          s1_r <= din[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // Edges are taken between settled stages only.
      assign level[g] = s2_r;
      assign rise[g] = s2_r & ~s3_r;
      assign fall[g] = ~s2_r & s3_r;
    end
  endgenerate
endmodule // sfl_pin_sync

// ===== rtl/sfl_fifo.sv
// Small read-data FIFO with registered head word.
module sfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage.
  logic [AW-1:0] wp_r, wp_nxt; // Write pointer.
  logic [AW-1:0] rp_r, rp_nxt; // Read pointer.
  logic [AW:0] cnt_r, cnt_nxt; // Words held.
  logic [WIDTH-1:0] head_r, head_nxt; // Registered head word.
  logic room_r, room_nxt; // Registered room-left flag.
  logic valid_r, valid_nxt; // Registered non-empty flag.
  logic wr, rd;

  // ==========================================================
  // Next pointers; the head register bypasses a write into an
  // empty slot so the word is seen on the same edge that writes it.
  always_comb begin
    wr = in_valid & room_r;
    rd = out_ready & valid_r;
    wp_nxt = wr ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = rd ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
    head_nxt = (wr && wp_r == rp_nxt) ? in_data : mem[rp_nxt];
    room_nxt = cnt_nxt != (AW+1)'(DEPTH);
    valid_nxt = cnt_nxt != '0;
  end

  // Register state; memory written on accepted words.
  always_ff @(posedge clk) begin
    if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      head_r <= '0;
      room_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      head_r <= head_nxt;
      room_r <= room_nxt;
      valid_r <= valid_nxt;
    end
    if (wr) begin
      mem[wp_r] <= in_data;
    end
  end

  assign in_ready = room_r;
  assign out_data = head_r;
  assign out_valid = valid_r;
endmodule // sfl_fifo

// ===== rtl/sfl_lane_if.sv
// Device-side serial flash lane interface: pins, framing, buffer.
`include "sfl_map.svh"
module sfl_lane_if (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic LANE0_I,
  input wire logic LANE1_I,
  input wire logic LANE2_I,
  input wire logic LANE3_I,
  output logic LANE0_O,
  output logic LANE1_O,
  output logic LANE2_O,
  output logic LANE3_O,
  output logic LANE0_OE,
  output logic LANE1_OE,
  output logic LANE2_OE,
  output logic LANE3_OE,
  input wire logic RESET_N,
  input wire logic EIGHT_PIN,
  input wire logic FOUR_LANE_ENABLE,
  input wire logic PIN_FUNC_RESET,
  output logic CMD_VALID,
  output logic [7:0] CMD_OPCODE,
  output logic [31:0] CMD_ADDR,
  output logic [12:0] CMD_SECTOR,
  output logic [8:0] CMD_BLOCK,
  output logic CMD_REJECT,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  output logic RD_READY,
  output logic HOLD_ACTIVE,
  output logic DEV_RESET
);
  import sfl_pkg::*;

  // ==========================================================
  // Pin sampling.
  logic [6:0] pin_lvl, pin_rise, pin_fall;
  logic sclk_lvl, sclk_rise, sclk_fall;
  logic cs_lvl, cs_fall;
  logic [3:0] lane_in; // Settled lane inputs.
  logic rstn_lvl;

  sfl_pin_sync #(.WIDTH(7)) u_sync (
    .clk(CLK),
    .srst(SRST),
    .din({RESET_N, LANE3_I, LANE2_I, LANE1_I, LANE0_I, CS_N, SCLK}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign sclk_lvl = pin_lvl[0];
  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign cs_lvl = pin_lvl[1];
  assign cs_fall = pin_fall[1];
  assign lane_in = pin_lvl[5:2];
  assign rstn_lvl = pin_lvl[6];

  // ==========================================================
  // Read data buffer between the user side and the lanes.
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic pop; // Head byte consumed by the shifter.
  logic restart_fire; // One-cycle restart event.

  sfl_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .clr(SRST | restart_fire),
    .in_data(RD_DATA),
    .in_valid(RD_VALID),
    .in_ready(RD_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // ==========================================================
  // Shared pin function and restart pulse measurement.
  logic shared_pin_fn; // Shared pin acts as pause or reset.
  logic restart_lvl; // Combined restart input level, low active.
  logic [7:0] rcnt_r, rcnt_nxt; // Low-time counter, saturating.

  // The shared pin only has a control role on small packages and
  // only while four lanes are off; otherwise it is a data lane.
  assign shared_pin_fn = EIGHT_PIN & ~FOUR_LANE_ENABLE;

  // Dedicated reset pin acts on large packages whatever the state;
  // on small ones the shared pin acts when so configured.
  always_comb begin
    restart_lvl = 1'b1;
    if (!EIGHT_PIN) begin
      restart_lvl = rstn_lvl;
    end else if (shared_pin_fn && PIN_FUNC_RESET) begin
      restart_lvl = lane_in[3];
    end
    rcnt_nxt = rcnt_r;
    if (restart_lvl) begin
      rcnt_nxt = '0;
    end else if (rcnt_r != `RESTART_CYC) begin
      rcnt_nxt = 8'(rcnt_r + 8'h01);
    end
    // Fires once, when the low time first reaches the minimum.
    restart_fire = ~restart_lvl &&
                   rcnt_r == 8'(`RESTART_CYC - 1);
  end

  // Restart counter register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rcnt_r <= '0;
    end else begin
      rcnt_r <= rcnt_nxt;
    end
  end

  // ==========================================================
  // Frame sequencer, pause logic and lane drivers.
  sfl_state_type st_r, st_nxt; // Frame phase.
  logic [5:0] cnt_r, cnt_nxt; // Shift clocks in this phase.
  logic [31:0] sr_r, sr_nxt; // Incoming shift register.
  logic [2:0] al_r, al_nxt; // Address lane width.
  logic [2:0] dl_r, dl_nxt; // Data lane width.
  logic [5:0] aclk_r, aclk_nxt; // Address phase length.
  logic [5:0] dum_r, dum_nxt; // Dummy phase length.
  logic [7:0] tx_r, tx_nxt; // Outgoing byte remainder.
  logic [2:0] txc_r, txc_nxt; // Chunks left in tx_r.
  logic hold_r, hold_nxt; // Pause in force.
  logic hpend_r, hpend_nxt; // Pause requested, clock still high.
  logic [3:0] lo_r, lo_nxt; // Lane output values.
  logic [3:0] oe_r, oe_nxt; // Lane output enables.
  logic cv_r, cv_nxt; // Command strobe.
  logic [7:0] op_r, op_nxt; // Captured opcode.
  logic [31:0] ad_r, ad_nxt; // Captured address.
  logic rej_r, rej_nxt; // Reject strobe.
  logic drst_r, drst_nxt; // Restart strobe.
  logic [7:0] byte_out; // Byte being split into chunks.
  logic [7:0] opc; // Opcode as it completes.

  // Next state of the whole frame.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sr_nxt = sr_r;
    al_nxt = al_r;
    dl_nxt = dl_r;
    aclk_nxt = aclk_r;
    dum_nxt = dum_r;
    tx_nxt = tx_r;
    txc_nxt = txc_r;
    hold_nxt = hold_r;
    hpend_nxt = hpend_r;
    lo_nxt = lo_r;
    oe_nxt = oe_r;
    op_nxt = op_r;
    ad_nxt = ad_r;
    cv_nxt = 1'b0;
    rej_nxt = 1'b0;
    drst_nxt = restart_fire;
    pop = 1'b0;
    byte_out = tx_r;
    opc = {sr_r[6:0], lane_in[0]};

    // Pause starts on the pin's fall with the clock low, or waits
    // for the clock to go low; it ends on the rise with clock low.
    if (shared_pin_fn && !PIN_FUNC_RESET && !cs_lvl) begin
      if (pin_fall[5]) begin
        hpend_nxt = 1'b1;
      end
      if ((hpend_r || pin_fall[5]) && !sclk_lvl && !lane_in[3]) begin
        hold_nxt = 1'b1;
        hpend_nxt = 1'b0;
      end
      if (hold_r && lane_in[3] && !sclk_lvl) begin
        hold_nxt = 1'b0;
        hpend_nxt = 1'b0;
      end
    end else begin
      hold_nxt = 1'b0;
      hpend_nxt = 1'b0;
    end

    if (restart_fire || cs_lvl) begin
      // Deselect, or restart: back to standby, lanes released.
      st_nxt = ST_IDLE;
      oe_nxt = 4'h0;
      txc_nxt = '0;
      hold_nxt = 1'b0;
      hpend_nxt = 1'b0;
    end else if (cs_fall) begin
      // Start of frame. A mode 3 host idles the clock high, so its
      // first falling edge lands in the command phase and is ignored.
      st_nxt = ST_CMD;
      cnt_nxt = '0;
      sr_nxt = '0;
      txc_nxt = '0;
    end else if (!hold_r && sclk_rise) begin
      // Inputs are captured on the rising clock only.
      cnt_nxt = 6'(cnt_r + 6'h01);
      case (st_r)
        ST_CMD: begin
          // Opcode is always a single-lane byte on the input line.
          sr_nxt = {sr_r[30:0], lane_in[0]};
          if (cnt_r == `OP_LAST) begin
            op_nxt = opc;
            cnt_nxt = '0;
            sr_nxt = '0;
            aclk_nxt = opc[2] ? `ADDR4_CLK : `ADDR3_CLK;
            st_nxt = ST_ADDR;
            case (opc)
              `OP_DUAL_OUT3, `OP_DUAL_OUT4: begin
                al_nxt = `LW1;
                dl_nxt = `LW2;
                dum_nxt = `DUMMY_OUT;
              end
              `OP_DUAL_IO3, `OP_DUAL_IO4: begin
                al_nxt = `LW2;
                dl_nxt = `LW2;
                dum_nxt = `DUMMY_DIO;
                aclk_nxt = opc[2] ? (`ADDR4_CLK >> 1) : (`ADDR3_CLK >> 1);
              end
              `OP_QUAD_OUT3, `OP_QUAD_OUT4: begin
                al_nxt = `LW1;
                dl_nxt = `LW4;
                dum_nxt = `DUMMY_OUT;
              end
              `OP_QUAD_IO3, `OP_QUAD_IO4: begin
                al_nxt = `LW4;
                dl_nxt = `LW4;
                dum_nxt = `DUMMY_QIO;
                aclk_nxt = opc[2] ? (`ADDR4_CLK >> 2) : (`ADDR3_CLK >> 2);
              end
              default: begin
                st_nxt = ST_IGNORE;
                rej_nxt = 1'b1;
              end
            endcase
            // Four-lane reads are refused while the enable is clear.
            if (opc[6:5] == 2'b11 || opc[6:5] == 2'b10 &&
                opc[7:4] == 4'h6) begin
              if (!FOUR_LANE_ENABLE) begin
                st_nxt = ST_IGNORE;
                rej_nxt = 1'b1;
              end
            end
          end
        end
        ST_ADDR: begin
          // Lane 0 is the low bit of each group of address bits.
          case (al_r)
            `LW2: sr_nxt = {sr_r[29:0], lane_in[1:0]};
            `LW4: sr_nxt = {sr_r[27:0], lane_in};
            default: sr_nxt = {sr_r[30:0], lane_in[0]};
          endcase
          if (cnt_r == 6'(aclk_r - 6'h01)) begin
            ad_nxt = sr_nxt;
            cv_nxt = 1'b1;
            cnt_nxt = '0;
            st_nxt = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (cnt_r == 6'(dum_r - 6'h01)) begin
            st_nxt = ST_DATA;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end else if (!hold_r && sclk_fall && st_r == ST_DATA) begin
      // Outputs change on the falling clock, a byte split into
      // two-bit or four-bit chunks, most significant chunk first.
      if (txc_r == '0) begin
        byte_out = fifo_valid ? fifo_data : `IDLE_BYTE;
        pop = fifo_valid;
      end
      if (dl_r == `LW4) begin
        lo_nxt = byte_out[7:4];
        tx_nxt = {byte_out[3:0], 4'h0};
        txc_nxt = (txc_r == '0) ? `CHUNK4_LAST : 3'(txc_r - 3'h1);
        // Lanes 2 and 3 are driven only with four lanes enabled.
        oe_nxt = FOUR_LANE_ENABLE ? 4'hf : 4'h3;
      end else begin
        lo_nxt = {2'b00, byte_out[7:6]};
        tx_nxt = {byte_out[5:0], 2'b00};
        txc_nxt = (txc_r == '0) ? `CHUNK2_LAST : 3'(txc_r - 3'h1);
        oe_nxt = 4'h3;
      end
    end

    // A paused device releases its outputs.
    if (hold_nxt) begin
      oe_nxt = 4'h0;
    end
  end

  // Frame state registers.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      sr_r <= '0;
      al_r <= `LW1;
      dl_r <= `LW1;
      aclk_r <= `ADDR3_CLK;
      dum_r <= `DUMMY_OUT;
      tx_r <= '0;
      txc_r <= '0;
      hold_r <= 1'b0;
      hpend_r <= 1'b0;
      lo_r <= 4'h0;
      oe_r <= 4'h0;
      cv_r <= 1'b0;
      op_r <= '0;
      ad_r <= '0;
      rej_r <= 1'b0;
      drst_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
      al_r <= al_nxt;
      dl_r <= dl_nxt;
      aclk_r <= aclk_nxt;
      dum_r <= dum_nxt;
      tx_r <= tx_nxt;
      txc_r <= txc_nxt;
      hold_r <= hold_nxt;
      hpend_r <= hpend_nxt;
      lo_r <= lo_nxt;
      oe_r <= oe_nxt;
      cv_r <= cv_nxt;
      op_r <= op_nxt;
      ad_r <= ad_nxt;
      rej_r <= rej_nxt;
      drst_r <= drst_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from registers. Sector and block numbers are the
  // address divided by 4K and 64K; pages are 256 bytes.
  assign {LANE3_O, LANE2_O, LANE1_O, LANE0_O} = lo_r;
  assign {LANE3_OE, LANE2_OE, LANE1_OE, LANE0_OE} = oe_r;
  assign CMD_VALID = cv_r;
  assign CMD_OPCODE = op_r;
  assign CMD_ADDR = ad_r;
  assign CMD_SECTOR = ad_r[`SECTOR_MSB:`SECTOR_LSB];
  assign CMD_BLOCK = ad_r[`BLOCK_MSB:`BLOCK_LSB];
  assign CMD_REJECT = rej_r;
  assign HOLD_ACTIVE = hold_r;
  assign DEV_RESET = drst_r;
endmodule // sfl_lane_if

// ===== verif/sfl_lane_if_sva.sv
// Port checker of the serial flash lane interface, with its bind.
`include "sfl_map.svh"
module sfl_lane_if_chk (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic LANE1_O,
  input wire logic LANE0_OE,
  input wire logic LANE1_OE,
  input wire logic LANE2_OE,
  input wire logic LANE3_OE,
  input wire logic EIGHT_PIN,
  input wire logic FOUR_LANE_ENABLE,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [31:0] CMD_ADDR,
  input wire logic [12:0] CMD_SECTOR,
  input wire logic [8:0] CMD_BLOCK,
  input wire logic CMD_REJECT,
  input wire logic HOLD_ACTIVE,
  input wire logic DEV_RESET
);
  // The four lane enables gathered into one word.
  logic [3:0] oe;
  assign oe = {LANE3_OE, LANE2_OE, LANE1_OE, LANE0_OE};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // ==========================================================
  // Lane drive.
  property p_lane_sets;
    oe inside {4'h0, 4'h3, 4'hf};
  endproperty
  a_lane_sets: assert property (p_lane_sets)
    else $error("lanes driven in a partial set");
  property p_upper_quiet;
    !FOUR_LANE_ENABLE |-> oe[3:2] == 2'b00;
  endproperty
  a_upper_quiet: assert property (p_upper_quiet)
    else $error("upper lanes driven without enable");
  // Six cycles cover the two-stage select synchroniser.
  property p_idle_quiet;
    CS_N [*6] |-> oe == 4'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("lanes driven while deselected");
  // A change of driven data must follow a low shift clock.
  property p_fall_shift;
    LANE1_OE && $changed(LANE1_O) |-> !SCLK && !$past(SCLK, 2);
  endproperty
  a_fall_shift: assert property (p_fall_shift)
    else $error("output changed away from a falling edge");
  // ==========================================================
  // Commands.
  property p_enable_gate;
    CMD_VALID |-> FOUR_LANE_ENABLE || !(CMD_OPCODE[7:4] inside {4'h6, 4'he});
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("four-lane command accepted while disabled");
  property p_known_op;
    CMD_VALID |-> CMD_OPCODE inside {`OP_DUAL_OUT3, `OP_DUAL_OUT4,
      `OP_DUAL_IO3, `OP_DUAL_IO4, `OP_QUAD_OUT3, `OP_QUAD_OUT4,
      `OP_QUAD_IO3, `OP_QUAD_IO4} && (!CMD_OPCODE[0] || !CMD_ADDR[31:24]);
  endproperty
  a_known_op: assert property (p_known_op)
    else $error("unexpected command or address width");
  property p_org;
    CMD_VALID |-> CMD_SECTOR == CMD_ADDR[24:12] &&
      CMD_BLOCK == CMD_ADDR[24:16];
  endproperty
  a_org: assert property (p_org)
    else $error("sector or block number off");
  // ==========================================================
  // Restart and pause.
  property p_restart;
    DEV_RESET |=> !DEV_RESET && oe == 4'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart left lanes driven or pulsed twice");
  property p_hold_start;
    $rose(HOLD_ACTIVE) |-> !SCLK && !FOUR_LANE_ENABLE && EIGHT_PIN;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("pause began in a wrong state");
  c_cmd: cover property (CMD_VALID);
  c_reject: cover property (CMD_REJECT);
  c_hold: cover property ($rose(HOLD_ACTIVE));
endmodule // sfl_lane_if_chk

bind sfl_lane_if sfl_lane_if_chk u_chk (
  .CLK(CLK), .SRST(SRST), .SCLK(SCLK), .CS_N(CS_N), .LANE1_O(LANE1_O),
  .LANE0_OE(LANE0_OE), .LANE1_OE(LANE1_OE), .LANE2_OE(LANE2_OE),
  .LANE3_OE(LANE3_OE), .EIGHT_PIN(EIGHT_PIN),
  .FOUR_LANE_ENABLE(FOUR_LANE_ENABLE), .CMD_VALID(CMD_VALID),
  .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR), .CMD_SECTOR(CMD_SECTOR),
  .CMD_BLOCK(CMD_BLOCK), .CMD_REJECT(CMD_REJECT),
  .HOLD_ACTIVE(HOLD_ACTIVE), .DEV_RESET(DEV_RESET)
);

// ===== verif/sfl_host_model.sv
// Host controller model: shift clock, select and the four lanes.
module sfl_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] drv,
  output logic [3:0] drv_en,
  input wire logic [3:0] lanes
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  // Idle: deselected, clock still, guard and pause pins held high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 4'hf;
    drv_en = 4'hc;
  end
  // One shift clock: fall, present lanes, rise, sample.
  task automatic cyc(input logic [3:0] v, input logic [3:0] en,
                     output logic [3:0] smp);
    sclk = 1'b0;
    drv = v;
    drv_en = en;
    #HALF;
    sclk = 1'b1;
    smp = lanes;
    #HALF;
  endtask
  // A whole read frame; released lanes are left to the wire model.
  task automatic frame(input bit m3, input logic [7:0] op,
      input logic [31:0] ad, input int nb, output logic [7:0] q[$]);
    int aw, dw, nd, na;
    logic [31:0] sh;
    logic [3:0] s;
    logic [7:0] by;
    aw = (op[7:4] == 4'hb) ? 2 : (op[7:4] == 4'he) ? 4 : 1;
    dw = (op[7:4] inside {4'h3, 4'hb}) ? 2 : 4;
    nd = (aw == 1) ? 8 : (aw == 2) ? 4 : 6;
    na = (op[3:0] == 4'hc) ? 32 : 24;
    sh = ad << (32 - na);
    q = {};
    sclk = m3;
    #HALF;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) cyc({3'b110, op[i]}, 4'hd, s);
    // Address goes out MSB first on as many lanes as the command uses.
    for (int i = 0; i < na / aw; i++) begin
      cyc((sh[31:28] >> (4 - aw)) | ((aw < 4) ? 4'hc : 4'h0),
          4'hc | 4'((1 << aw) - 1), s);
      sh = sh << aw;
    end
    for (int i = 0; i < nd; i++) cyc(4'hf, (dw == 4) ? 4'h0 : 4'hc, s);
    for (int b = 0; b < nb; b++) begin
      by = 8'h00;
      for (int k = 0; k < 8 / dw; k++) begin
        cyc(4'hf, (dw == 4) ? 4'h0 : 4'hc, s);
        by = (by << dw) | 8'(s & 4'((1 << dw) - 1));
      end
      q.push_back(by);
    end
    if (!m3) begin
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    #HALF;
    drv_en = 4'hc;
  endtask
  // Pulls the shared pin low for a while, selected or not.
  task automatic pulse3(input bit sel, input realtime t);
    sclk = 1'b0;
    cs_n = !sel;
    #100;
    drv[3] = 1'b0;
    #t;
    drv[3] = 1'b1;
    #100;
    cs_n = 1'b1;
  endtask
endmodule // sfl_host_model

// ===== verif/test_serial_flash_lane_interface.sv
// Self-checking bench of the serial flash lane interface.
`include "sfl_map.svh"
module test_serial_flash_lane_interface;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK_EQ(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: %h, expected %h", $time, got, exp); \
    end \
  end
  logic clk, srst, reset_n, eight_pin, four_en, pin_reset, rd_valid, tog;
  logic sclk, cs_n, rd_ready, cmd_valid, cmd_reject, hold_act, dev_rst;
  logic [7:0] rd_data, cmd_op, c_op;
  logic [3:0] h_o, h_en;
  wire logic [3:0] d_o, d_oe, lane_w;
  logic [31:0] cmd_addr, c_addr, seed, ea;
  logic [12:0] cmd_sec, c_sec;
  logic [8:0] cmd_blk, c_blk;
  logic [7:0] ops[8];
  logic [7:0] exp_q[$], got_q[$];
  int miscompares, checks_done, n_cmd, n_rej, n_rst;
  // Wire model: device first, then host, else pull-up or a toggle.
  assign lane_w = (d_oe & d_o) | (~d_oe & h_en & h_o)
    | (~d_oe & ~h_en & {2'b11, tog, ~tog});
  sfl_lane_if u_dut (
    .CLK(clk), .SRST(srst), .SCLK(sclk), .CS_N(cs_n),
    .LANE0_I(lane_w[0]), .LANE1_I(lane_w[1]),
    .LANE2_I(lane_w[2]), .LANE3_I(lane_w[3]),
    .LANE0_O(d_o[0]), .LANE1_O(d_o[1]), .LANE2_O(d_o[2]),
    .LANE3_O(d_o[3]), .LANE0_OE(d_oe[0]), .LANE1_OE(d_oe[1]),
    .LANE2_OE(d_oe[2]), .LANE3_OE(d_oe[3]), .RESET_N(reset_n),
    .EIGHT_PIN(eight_pin), .FOUR_LANE_ENABLE(four_en),
    .PIN_FUNC_RESET(pin_reset), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(cmd_op), .CMD_ADDR(cmd_addr), .CMD_SECTOR(cmd_sec),
    .CMD_BLOCK(cmd_blk), .CMD_REJECT(cmd_reject), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .RD_READY(rd_ready),
    .HOLD_ACTIVE(hold_act), .DEV_RESET(dev_rst)
  );
  sfl_host_model u_host (
    .sclk(sclk), .cs_n(cs_n), .drv(h_o), .drv_en(h_en), .lanes(lane_w)
  );
  // ==========================================================
  // Clock, monitors and helpers.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are counted; command fields are kept from their pulse.
  always @(posedge clk) begin
    tog <= ~tog;
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      c_op = cmd_op;
      c_addr = cmd_addr;
      c_sec = cmd_sec;
      c_blk = cmd_blk;
    end
    if (cmd_reject === 1'b1) n_rej++;
    if (dev_rst === 1'b1) n_rst++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pushes random bytes until the buffer refuses one.
  task automatic fill();
    exp_q = {};
    @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      rd_data <= seed[7:0];
      rd_valid <= 1'b1;
      @(posedge clk);
      if (rd_ready !== 1'b1) break;
      exp_q.push_back(seed[7:0]);
    end
    rd_valid <= 1'b0;
  endtask
  // A low pulse of the dedicated reset pin, counted afterwards.
  task automatic low_pulse(input int n, input int want);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK_EQ(n_rst, want)
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A hang is cut short here.
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // ==========================================================
  // Main sequence.
  initial begin
    {tog, reset_n, four_en, rd_data} = {1'b0, 1'b1, 1'b1, 8'h00};
    {srst, eight_pin, pin_reset, rd_valid} = 4'h8;
    {miscompares, checks_done, n_cmd, n_rej, n_rst} = '0;
    seed = 32'h81a6;
    ops = '{`OP_DUAL_OUT3, `OP_DUAL_OUT4, `OP_DUAL_IO3, `OP_DUAL_IO4,
            `OP_QUAD_OUT3, `OP_QUAD_OUT4, `OP_QUAD_IO3, `OP_QUAD_IO4};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK_EQ(d_oe, 4'h0)
    $display("test reset done");
    low_pulse(200, 0);
    low_pulse(260, 1);
    $display("test restart done");
    // Each read command, alternating clock modes, one byte past empty.
    for (int i = 0; i < 8; i++) begin
      fill();
      `CHK_EQ(exp_q.size(), 8)
      seed = lfsr(seed);
      u_host.frame(i[0], ops[i], seed, 9, got_q);
      ea = ops[i][0] ? {8'h00, seed[23:0]} : seed;
      exp_q.push_back(`IDLE_BYTE);
      `CHK_EQ(n_cmd, i + 1)
      `CHK_EQ(c_op, ops[i])
      `CHK_EQ(c_addr, ea)
      `CHK_EQ({c_sec, c_blk}, {ea[24:12], ea[24:16]})
      for (int k = 0; k < 9; k++) `CHK_EQ(got_q[k], exp_q[k])
    end
    $display("test reads done");
    @(posedge clk);
    four_en <= 1'b0;
    u_host.frame(1'b0, `OP_QUAD_IO3, seed, 0, got_q);
    u_host.frame(1'b1, 8'h03, seed, 0, got_q);
    @(posedge clk);
    `CHK_EQ({n_rej, n_cmd}, {32'd2, 32'd8})
    $display("test refusals done");
    eight_pin <= 1'b1;
    fork
      u_host.pulse3(1'b1, 400);
      begin
        repeat (75) @(posedge clk);
        `CHK_EQ(hold_act, 1'b1)
        repeat (60) @(posedge clk);
        `CHK_EQ(hold_act, 1'b0)
      end
    join
    $display("test pause done");
    pin_reset <= 1'b1;
    u_host.pulse3(1'b0, 1100);
    @(posedge clk);
    `CHK_EQ(n_rst, 2)
    four_en <= 1'b1;
    u_host.pulse3(1'b0, 1100);
    @(posedge clk);
    `CHK_EQ(n_rst, 2)
    $display("test shared pin done");
    close_out();
  end
endmodule // test_serial_flash_lane_interface
